/* File: hdl/serial_eeprom_regs.vh */
`ifndef SERIAL_EEPROM_REGS_VH
`define SERIAL_EEPROM_REGS_VH

// ****************************************
// Address byte layout
// ****************************************
`define DEV_TYPE_ARRAY   4'hA
`define DEV_TYPE_PROTECT 4'h6
`define RW_READ          1'b1

// ****************************************
// Array geometry
// ****************************************
`define MEM_ADDR_W       8
`define PAGE_ADDR_W      4
`define PAGE_SIZE        16
`define BITS_PER_BYTE    4'h8
`define LAST_TX_BIT      4'h7
`define FIFO_DEPTH       4

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ          40
`define T_WR_US          10000
`define PROG_CYCLES      (`T_WR_US * `CLK_MHZ)
`define PROG_CNT_W       20

`endif

/* File: hdl/serial_eeprom_store.v */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Byte memory, registered read
// ****************************************
module serial_eeprom_store #(
    parameter integer AW = 8,
    parameter integer DW = 8
) (
    // Clock
    input  wire          clk_in,
    // Write port
    input  wire          we_in,
    input  wire [AW-1:0] waddr_in,
    input  wire [DW-1:0] wdata_in,
    // Read port
    input  wire [AW-1:0] raddr_in,
    output reg  [DW-1:0] rdata_out
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        rdata_out <= mem[raddr_in];
    end
endmodule

// ****************************************
// Read prefetch FIFO
// ****************************************
module serial_eeprom_fifo #(
    parameter integer WIDTH = 8,
    parameter integer DEPTH = 4,
    parameter integer PTR_W = 2
) (
    // Clock and reset
    input  wire             clk_in,
    input  wire             resetn_in,
    input  wire             flush_in,
    // Fill side
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    // Drain side
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] buf_q [0:DEPTH-1];
    reg [PTR_W-1:0] wr_q;
    reg [PTR_W-1:0] rd_q;
    reg [PTR_W:0]   cnt_q;
    wire            push;
    wire            pop;

    assign in_ready_out  = (cnt_q != DEPTH[PTR_W:0]);
    assign out_valid_out = (cnt_q != {(PTR_W+1){1'b0}});
    assign out_data_out  = buf_q[rd_q];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    // Wrap by compare so depth need not be a power of two
    function [PTR_W-1:0] nxt(input [PTR_W-1:0] p);
        begin
            nxt = (p == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : p + 1'b1;
        end
    endfunction

    always @(posedge clk_in) begin
        if (!resetn_in || flush_in) begin
            wr_q  <= {PTR_W{1'b0}};
            rd_q  <= {PTR_W{1'b0}};
            cnt_q <= {(PTR_W+1){1'b0}};
        end else begin
            if (push) begin
                buf_q[wr_q] <= in_data_in;
                wr_q        <= nxt(wr_q);
            end
            if (pop) begin
                rd_q <= nxt(rd_q);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

/* File: hdl/serial_eeprom_bus_slave.v */
// Operation
// - SDA changes only while SCL low
// - Start detected always; ignore bus before it (the code ignores start while busy_out is high)
// - Stop ends transaction, returns to standby
// - Receiver acknowledges on ninth clock low
// - Acknowledge matched address and written bytes
// - Read continues on ack, stops otherwise
// - Array accesses need device type 1010
// - Three straps must match address bits
// - Last address bit: 1 read, 0 write
// - Write: word address then data, both acked
// - Stop after write starts silent programming
// - Page write takes up to sixteen bytes
// - Write address advances, wraps within page
// - No address ack while programming runs
// - One-time protect blocks lowest 128 bytes
// - Protect register ignored after first write
// - Protect reached with type 0110, bytes ignored
// - Protected locations below 128 stay unchanged
// - Read address wraps over all eight bits
`timescale 1ns/1ps
`default_nettype none
`include "serial_eeprom_regs.vh"
module serial_eeprom_bus_slave #(
    parameter integer PROG_CYCLES = `PROG_CYCLES,
    parameter integer FIFO_DEPTH  = `FIFO_DEPTH
) (
    // Clock and reset
    input  wire clk_in,
    input  wire resetn_in,
    // Bus pins
    input  wire scl_in,
    input  wire sda_in,
    output reg  sda_out_out,
    output reg  sda_oe_out,
    // Address straps
    input  wire strap_addr_bit0_in,
    input  wire strap_addr_bit1_in,
    input  wire strap_addr_bit2_in,
    // Status
    output reg  busy_out,
    output reg  protected_out
);
    // ****************************************
    // States
    // ****************************************
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_RX   = 3'h1;
    localparam [2:0] S_ACK  = 3'h2;
    localparam [2:0] S_TX   = 3'h3;
    localparam [2:0] S_MACK = 3'h4;
    localparam [1:0] K_DEV  = 2'h0;
    localparam [1:0] K_WADR = 2'h1;
    localparam [1:0] K_DATA = 2'h2;
    localparam [`PROG_CNT_W-1:0] PROG_LAST = PROG_CYCLES[`PROG_CNT_W-1:0] - 1'b1;
    // ****************************************
    // Declarations
    // ****************************************
    reg                   scl_s1_q, scl_s2_q, scl_s3_q;
    reg                   sda_s1_q, sda_s2_q, sda_s3_q;
    reg  [2:0]            strap_s1_q;
    reg  [2:0]            strap_s2_q;
    reg  [2:0]            state_q;
    reg  [1:0]            kind_q;
    reg  [3:0]            cnt_q;
    reg  [7:0]            shift_q;
    reg  [7:0]            tx_q;
    reg                   rd_sel_q;
    reg                   wp_sel_q;
    reg                   wp_req_q;
    reg                   mack_q;
    reg  [7:0]            addr_q;
    reg  [3:0]            page_hi_q;
    reg  [`PAGE_SIZE-1:0] mask_q;
    reg                   pb_we_q;
    reg  [3:0]            pb_waddr_q;
    reg  [7:0]            pb_wdata_q;
    reg  [`PROG_CNT_W-1:0] prog_cnt_q;
    reg  [4:0]            copy_idx_q;
    reg                   copy_pend_q;
    reg  [3:0]            copy_rd_idx_q;
    reg                   arr_we_q;
    reg  [7:0]            arr_waddr_q;
    reg  [7:0]            arr_wdata_q;
    reg                   fetch_on_q;
    reg                   fetch_pend_q;
    reg  [7:0]            fetch_ptr_q;
    reg                   flush_q;
    wire                  fifo_in_ready;
    wire                  fifo_out_valid;
    wire [7:0]            fifo_out_data;
    wire [7:0]            arr_rdata;
    wire [7:0]            pb_rdata;
    // Device type plus straps decide whether an address byte is ours
    function addr_hit(input [7:0] b, input [3:0] dtype, input [2:0] strap);
        begin
            addr_hit = (b[7:4] == dtype) && (b[3:1] == strap);
        end
    endfunction
    // ****************************************
    // Pin sampling and bus conditions
    // ****************************************
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            {scl_s3_q, scl_s2_q, scl_s1_q} <= 3'h7;
            {sda_s3_q, sda_s2_q, sda_s1_q} <= 3'h7;
            strap_s1_q <= 3'h0;
            strap_s2_q <= 3'h0;
        end else begin
            {scl_s3_q, scl_s2_q, scl_s1_q} <= {scl_s2_q, scl_s1_q, scl_in};
            {sda_s3_q, sda_s2_q, sda_s1_q} <= {sda_s2_q, sda_s1_q, sda_in};
            strap_s1_q <= {strap_addr_bit2_in, strap_addr_bit1_in, strap_addr_bit0_in};
            strap_s2_q <= strap_s1_q;
        end
    end
    wire                  scl_rise   = scl_s2_q & ~scl_s3_q;
    wire                  scl_fall   = ~scl_s2_q & scl_s3_q;
    // SDA moving while SCL stays high is a marker, never data
    wire                  start_seen = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    wire                  stop_seen  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
    // Pop on the clock low that starts the next byte out
    wire                  load_tx    = ~busy_out & scl_fall & ~start_seen & ~stop_seen &
                                       (((state_q == S_ACK) & rd_sel_q) |
                                        ((state_q == S_MACK) & mack_q));
    // Empty FIFO sends all ones, which leaves the line released
    wire [7:0]            tx_next    = fifo_out_valid ? fifo_out_data : 8'hFF;
    // One read in flight keeps the FIFO room check honest
    wire                  fetch_go   = fetch_on_q & ~fetch_pend_q & fifo_in_ready & ~flush_q;
    // ****************************************
    // Protocol engine
    // ****************************************
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            state_q    <= S_IDLE;
            kind_q     <= K_DEV;
            cnt_q      <= 4'h0;
            shift_q    <= 8'h00;
            tx_q       <= 8'hFF;
            rd_sel_q   <= 1'b0;
            wp_sel_q   <= 1'b0;
            wp_req_q   <= 1'b0;
            mack_q     <= 1'b0;
            addr_q     <= 8'h00;
            page_hi_q  <= 4'h0;
            mask_q     <= {`PAGE_SIZE{1'b0}};
            pb_we_q    <= 1'b0;
            fetch_on_q <= 1'b0;
            flush_q    <= 1'b0;
            sda_out_out <= 1'b0;
            sda_oe_out <= 1'b0;
        end else begin
            pb_we_q <= 1'b0;
            flush_q <= 1'b0;
            sda_out_out <= 1'b0;
            if (load_tx) begin
                tx_q       <= tx_next;
                sda_oe_out <= ~tx_next[7];
                addr_q     <= addr_q + 8'h01;
                state_q    <= S_TX;
                cnt_q      <= 4'h0;
            end
            if (busy_out) begin
                // Inputs are dead while the array programs
                state_q    <= S_IDLE;
                sda_oe_out <= 1'b0;
                fetch_on_q <= 1'b0;
            end else if (start_seen) begin
                state_q    <= S_RX;
                kind_q     <= K_DEV;
                cnt_q      <= 4'h0;
                mask_q     <= {`PAGE_SIZE{1'b0}};
                wp_req_q   <= 1'b0;
                fetch_on_q <= 1'b0;
                sda_oe_out <= 1'b0;
            end else if (stop_seen) begin
                state_q    <= S_IDLE;
                sda_oe_out <= 1'b0;
                fetch_on_q <= 1'b0;
            end else begin
                case (state_q)
                    S_RX: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s2_q};
                            cnt_q   <= cnt_q + 4'h1;
                        end else if (scl_fall && cnt_q == `BITS_PER_BYTE) begin
                            cnt_q      <= 4'h0;
                            state_q    <= S_ACK;
                            sda_oe_out <= 1'b1;
                            case (kind_q)
                                K_DEV: begin
                                    kind_q   <= K_WADR;
                                    rd_sel_q <= (shift_q[0] == `RW_READ);
                                    wp_sel_q <= 1'b0;
                                    if (addr_hit(shift_q, `DEV_TYPE_ARRAY, strap_s2_q)) begin
                                        if (shift_q[0] == `RW_READ) begin
                                            fetch_on_q <= 1'b1;
                                            flush_q    <= 1'b1;
                                        end
                                    end else if (addr_hit(shift_q, `DEV_TYPE_PROTECT,
                                                          strap_s2_q) &&
                                                 !protected_out &&
                                                 shift_q[0] != `RW_READ) begin
                                        wp_sel_q <= 1'b1;
                                    end else begin
                                        // Not ours, a protect read, or protect already used
                                        state_q    <= S_IDLE;
                                        sda_oe_out <= 1'b0;
                                    end
                                end
                                K_WADR: begin
                                    kind_q <= K_DATA;
                                    if (!wp_sel_q) begin
                                        addr_q    <= shift_q;
                                        page_hi_q <= shift_q[7:4];
                                    end
                                end
                                default: begin
                                    if (wp_sel_q) begin
                                        wp_req_q <= 1'b1;
                                    end else begin
                                        pb_we_q    <= 1'b1;
                                        pb_waddr_q <= addr_q[3:0];
                                        pb_wdata_q <= shift_q;
                                        mask_q[addr_q[3:0]] <= 1'b1;
                                        addr_q[3:0] <= addr_q[3:0] + 4'h1;
                                    end
                                end
                            endcase
                        end
                    end
                    S_ACK: begin
                        if (scl_fall && !rd_sel_q) begin
                            sda_oe_out <= 1'b0;
                            state_q    <= S_RX;
                        end
                    end
                    S_TX: begin
                        if (scl_fall) begin
                            if (cnt_q == `LAST_TX_BIT) begin
                                sda_oe_out <= 1'b0;
                                state_q    <= S_MACK;
                                cnt_q      <= 4'h0;
                            end else begin
                                tx_q       <= {tx_q[6:0], 1'b1};
                                sda_oe_out <= ~tx_q[6];
                                cnt_q      <= cnt_q + 4'h1;
                            end
                        end
                    end
                    S_MACK: begin
                        if (scl_rise) begin
                            mack_q <= ~sda_s2_q;
                        end else if (scl_fall && !mack_q) begin
                            // No ack: stay off the bus until next start
                            state_q    <= S_IDLE;
                            fetch_on_q <= 1'b0;
                        end
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end
    // ****************************************
    // Programming cycle and protect bit
    // ****************************************
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            busy_out      <= 1'b0;
            protected_out <= 1'b0;
            prog_cnt_q    <= {`PROG_CNT_W{1'b0}};
            copy_idx_q    <= 5'h10;
            copy_pend_q   <= 1'b0;
            copy_rd_idx_q <= 4'h0;
            arr_we_q      <= 1'b0;
        end else begin
            arr_we_q    <= 1'b0;
            copy_pend_q <= 1'b0;
            if (!busy_out) begin
                if (stop_seen && state_q != S_IDLE && ((|mask_q) || wp_req_q)) begin
                    busy_out   <= 1'b1;
                    prog_cnt_q <= PROG_LAST;
                    copy_idx_q <= 5'h00;
                end
            end else begin
                if (!copy_idx_q[4]) begin
                    copy_pend_q   <= 1'b1;
                    copy_rd_idx_q <= copy_idx_q[3:0];
                    copy_idx_q    <= copy_idx_q + 5'h01;
                end
                if (copy_pend_q) begin
                    // Lower half stays untouched once protected
                    arr_we_q <= mask_q[copy_rd_idx_q] &
                                ~(protected_out & ~page_hi_q[3]);
                    arr_waddr_q <= {page_hi_q, copy_rd_idx_q};
                    arr_wdata_q <= pb_rdata;
                end
                if (prog_cnt_q == {`PROG_CNT_W{1'b0}}) begin
                    busy_out <= 1'b0;
                    if (wp_req_q) begin
                        // Sticky; only reset clears it here
                        protected_out <= 1'b1;
                    end
                end else begin
                    prog_cnt_q <= prog_cnt_q - 1'b1;
                end
            end
        end
    end
    // ****************************************
    // Read prefetch
    // ****************************************
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            fetch_pend_q <= 1'b0;
            fetch_ptr_q  <= 8'h00;
        end else if (flush_q) begin
            fetch_pend_q <= 1'b0;
            fetch_ptr_q  <= addr_q;
        end else begin
            fetch_pend_q <= fetch_go;
            if (fetch_go) begin
                fetch_ptr_q <= fetch_ptr_q + 8'h01;
            end
        end
    end
    // ****************************************
    // Storage
    // ****************************************
    serial_eeprom_store #(.AW(`MEM_ADDR_W), .DW(8)) u_array (
        .clk_in    (clk_in),
        .we_in     (arr_we_q),
        .waddr_in  (arr_waddr_q),
        .wdata_in  (arr_wdata_q),
        .raddr_in  (fetch_ptr_q),
        .rdata_out (arr_rdata)
    );
    // Page staged here so an aborted write never reaches the array
    serial_eeprom_store #(.AW(`PAGE_ADDR_W), .DW(8)) u_page (
        .clk_in    (clk_in),
        .we_in     (pb_we_q),
        .waddr_in  (pb_waddr_q),
        .wdata_in  (pb_wdata_q),
        .raddr_in  (copy_idx_q[3:0]),
        .rdata_out (pb_rdata)
    );
    serial_eeprom_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .PTR_W(2)) u_fifo (
        .clk_in        (clk_in),
        .resetn_in     (resetn_in),
        .flush_in      (flush_q),
        .in_valid_in   (fetch_pend_q & ~flush_q),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (arr_rdata),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (load_tx),
        .out_data_out  (fifo_out_data)
    );
endmodule

`default_nettype wire

/* File: tb/serial_eeprom_bus_slave_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module serial_eeprom_bus_slave_asserts #(
    parameter integer PROG_CYCLES = 400000
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out_out,
    input wire logic sda_oe_out,
    input wire logic strap_addr_bit0_in,
    input wire logic strap_addr_bit1_in,
    input wire logic strap_addr_bit2_in,
    input wire logic busy_out,
    input wire logic protected_out
);
    // Length of the current busy stretch
    logic [19:0] busy_cnt_q;
    always @(posedge clk_in) begin
        if (!resetn_in || !busy_out)
            busy_cnt_q <= 20'h0;
        else
            busy_cnt_q <= busy_cnt_q + 20'h1;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    property p_open_drain; sda_out_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda driven high");
    property p_oe_scl_low; $changed(sda_oe_out) |-> !$past(scl_in, 2); endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved, scl high");
    property p_busy_quiet; busy_out |-> !sda_oe_out; endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
    property p_busy_cause; $rose(busy_out) |-> scl_in && sda_in && $past(scl_in, 3); endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without stop");
    property p_busy_max; busy_out |-> busy_cnt_q < PROG_CYCLES; endproperty
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    property p_busy_len; $fell(busy_out) |-> busy_cnt_q == PROG_CYCLES; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_prot_keep; !$fell(protected_out); endproperty
    a_prot_keep: assert property (p_prot_keep) else $error("protect cleared");
    property p_prot_set; $rose(protected_out) |-> $past(busy_out, 2); endproperty
    a_prot_set: assert property (p_prot_set) else $error("protect set unprogrammed");
endmodule
bind serial_eeprom_bus_slave serial_eeprom_bus_slave_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out_out(sda_out_out), .sda_oe_out(sda_oe_out),
    .strap_addr_bit0_in(strap_addr_bit0_in), .strap_addr_bit1_in(strap_addr_bit1_in),
    .strap_addr_bit2_in(strap_addr_bit2_in), .busy_out(busy_out),
    .protected_out(protected_out));
`default_nettype wire

/* File: tb/bus_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bus master model
// ****************************************
module bus_master_model (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output var  logic scl_out,
    output var  logic sda_oe_out
);
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    // Four cycles a phase: 200 ns bit period
    task automatic half();
        repeat (4) @(negedge clk_in);
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_oe_out = ~b;
        half();
        scl_out = 1'b1;
        half();
        s = sda_in;
        scl_out = 1'b0;
    endtask
    task automatic start();
        sda_oe_out = 1'b0;
        half();
        scl_out = 1'b1;
        half();
        sda_oe_out = 1'b1;
        half();
        scl_out = 1'b0;
    endtask
    task automatic stop();
        sda_oe_out = 1'b1;
        half();
        scl_out = 1'b1;
        half();
        sda_oe_out = 1'b0;
        half();
    endtask
    // Ninth bit nb: 1 releases, 0 acknowledges
    task automatic xfer(input logic [7:0] d, input logic nb, output logic [7:0] q,
                        output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(nb, s);
        ack = ~s;
    endtask
endmodule
`default_nettype wire

/* File: tb/serial_eeprom_bus_slave_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench
// ****************************************
module serial_eeprom_bus_slave_tb;
    // Short programming time keeps the run small
    localparam integer PROG = 128;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [2:0] strap = 3'h5;
    // Address the master sends, apart from the pins
    logic [2:0] adr = 3'h5;
    int checks = 0;
    int n_fail = 0;
    int cyc = 0;
    wire logic scl, m_oe, d_oe, d_out, busy, prot;
    // Pull-up wire, low when anyone pulls
    wire logic sda = ~(m_oe | d_oe);
    always #12.5 clk_in = ~clk_in;
    serial_eeprom_bus_slave #(.PROG_CYCLES(PROG)) u_dut (
        .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda),
        .sda_out_out(d_out), .sda_oe_out(d_oe), .strap_addr_bit0_in(strap[0]),
        .strap_addr_bit1_in(strap[1]), .strap_addr_bit2_in(strap[2]),
        .busy_out(busy), .protected_out(prot));
    bus_master_model u_mst (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
    task automatic close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic sel(input logic [3:0] ty, input logic rw, output logic ack);
        logic [7:0] q;
        u_mst.start();
        u_mst.xfer({ty, adr, rw}, 1'b1, q, ack);
    endtask
    task automatic snd(input logic [7:0] d, output logic ack);
        logic [7:0] q;
        u_mst.xfer(d, 1'b1, q, ack);
    endtask
    task automatic idle();
        for (int i = 0; i < 300 && busy !== 1'b0; i++)
            @(negedge clk_in);
    endtask
    task automatic wr(input logic [3:0] ty, input logic [7:0] a, input logic [7:0] d,
                      input logic e);
        logic k0, k1, k2;
        sel(ty, 1'b0, k0);
        snd(a, k1);
        snd(d, k2);
        u_mst.stop();
        chk("wr_ack", {5'h0, e, e, e}, {5'h0, k0, k1, k2});
    endtask
    task automatic rd_at(input logic [7:0] a);
        logic k0, k1, k2;
        sel(4'hA, 1'b0, k0);
        snd(a, k1);
        sel(4'hA, 1'b1, k2);
        chk("rd_ack", 8'h07, {5'h0, k0, k1, k2});
    endtask
    task automatic rcv(input logic [7:0] e, input logic nb);
        logic [7:0] q;
        logic k;
        u_mst.xfer(8'hFF, nb, q, k);
        chk("rd_data", e, q);
    endtask
    task automatic s_byte();
        logic k;
        wr(4'hA, 8'h00, 8'h5A, 1'b1);
        chk("busy", 8'h01, {7'h0, busy});
        sel(4'hA, 1'b0, k);
        u_mst.stop();
        chk("poll_busy", 8'h00, {7'h0, k});
        idle();
        sel(4'hA, 1'b0, k);
        u_mst.stop();
        chk("poll_done", 8'h01, {7'h0, k});
        rd_at(8'h00);
        rcv(8'h5A, 1'b1);
        rcv(8'hFF, 1'b1);
        u_mst.stop();
    endtask
    task automatic s_page();
        logic k;
        sel(4'hA, 1'b0, k);
        snd(8'hF0, k);
        for (int i = 0; i < 18; i++) begin
            snd(i[7:0], k);
            chk("pg_ack", 8'h01, {7'h0, k});
        end
        u_mst.stop();
        idle();
        rd_at(8'hF0);
        rcv(8'h10, 1'b0);
        rcv(8'h11, 1'b0);
        rcv(8'h02, 1'b1);
        u_mst.stop();
        rd_at(8'hFE);
        rcv(8'h0E, 1'b0);
        rcv(8'h0F, 1'b0);
        rcv(8'h5A, 1'b1);
        u_mst.stop();
    endtask
    task automatic s_reject();
        logic k;
        wr(4'hB, 8'h00, 8'h77, 1'b0);
        strap = 3'h2;
        wr(4'hA, 8'h00, 8'h77, 1'b0);
        strap = 3'h5;
        sel(4'h6, 1'b1, k);
        u_mst.stop();
        chk("prot_rd", 8'h00, {7'h0, k});
        idle();
        rd_at(8'h00);
        rcv(8'h5A, 1'b1);
        u_mst.stop();
    endtask
    task automatic s_prot();
        wr(4'h6, 8'h12, 8'h34, 1'b1);
        idle();
        chk("prot", 8'h01, {7'h0, prot});
        wr(4'hA, 8'h00, 8'hEE, 1'b1);
        idle();
        wr(4'hA, 8'h80, 8'h33, 1'b1);
        idle();
        rd_at(8'h00);
        rcv(8'h5A, 1'b1);
        u_mst.stop();
        rd_at(8'h80);
        rcv(8'h33, 1'b1);
        u_mst.stop();
        wr(4'h6, 8'h12, 8'h34, 1'b0);
        chk("prot_kept", 8'h01, {7'h0, prot});
    endtask
    initial begin
        repeat (6) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (4) @(negedge clk_in);
        s_byte();
        s_page();
        s_reject();
        s_prot();
        close_out();
    end
endmodule
`default_nettype wire
